// ===== shared/homing_pkg.sv
// Constants for the axis homing sequencer: register map, reset values,
// method codes and feedback selections.
// Assumes a 32-bit register port with word-aligned byte offsets.
package homing_pkg;
	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_VELOCITY = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ACCEL    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_DECEL    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_POSITION = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_DISTANCE = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_FACTOR   = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_READOUT  = 8'h24;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTL_START_STOP = 0;
	localparam int CTL_CAPTURE    = 1;
	localparam int MODE_METH_LSB  = 0;
	localparam int MODE_DIR_BIT   = 2;
	localparam int MODE_FB_LSB    = 8;

	// ---------------------------------------------------------------
	// Method codes and index-capable feedback selections
	// ---------------------------------------------------------------
	localparam logic [1:0] METH_CURRENT = 2'h0;
	localparam logic [1:0] METH_LIMIT   = 2'h1;
	localparam logic [1:0] METH_ZERO    = 2'h2;
	localparam logic [1:0] METH_INDEX   = 2'h3;
	localparam logic [7:0] FB_INDEX_A   = 8'h0a;
	localparam logic [7:0] FB_INDEX_B   = 8'h0b;
	localparam logic [7:0] FB_INDEX_C   = 8'h14;
	localparam logic [7:0] FB_INDEX_D   = 8'h15;

	// ---------------------------------------------------------------
	// Reset values and scaling
	// ---------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
	localparam logic [6:0]        RST_FACTOR = 7'h32;
	localparam logic [6:0]        PERCENT_FULL = 7'h64;
endpackage

// ===== src/axis_homing_sequencer.sv
// Homing sequencer for one servo axis: current-position, limit,
// limit then zero angle, and limit then index methods.
// Assumes a motion profile that ramps toward vel_cmd_o with the given
// ramps, executes absolute moves, and reports standstill and move end.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Found flag rises once the home reference is established.
// - Done flag rises when the whole homing move, offset included, ends.
// - Active flag is high while homing runs, low afterwards.
// - Error flag rises when any homing step fails.
// - Start/stop command starts the selected method or aborts a running one.
// - Method 0 takes present position as home, no search motion.
// - Nonzero distance offset causes a final move, in every method.
// - At home the position feedback is loaded with home position value.
// - Limit methods start moving in the configured home direction.
// - At the limit switch the motor stops and then reverses.
// - Method 1 loads positions on limit release, then ramps to zero.
// - After ramp to zero, move to home position plus distance.
// - Limit release before standstill and reversal raises a homing error.
// - Method 2 loads home value plus distance to zero angle.
// - Method 2 then moves to home plus offset, at zero angle.
// - Mechanical zero angle is a feedback angle of zero.
// - Method 3 allowed only with feedback selections 10, 11, 20, 21.
// - Method 3 needs index capture armed by host; device uses it.
// - Method 3 searches index at reduced velocity after limit release.
// - Method 3 loads positions on index, ramps to zero, moves offset.
// - Method codes: 0 current, 1 limit, 2 zero angle, 3 index.
// - Reduced search velocity is a percentage of homing velocity.
module axis_homing_sequencer #(
	parameter int ANGLE_W = 16
) (
	// Clock and reset
	input  wire logic                            clock_i,
	input  wire logic                            reset_i,
	// Register port
	input  wire logic [homing_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [homing_pkg::DATA_W-1:0]   wdata_i,
	input  wire logic                            write_i,
	input  wire logic                            read_i,
	output logic      [homing_pkg::DATA_W-1:0]   rdata_o,
	// Limit switch and index pins, active low switches
	input  wire logic                            limit_pos_n_i,
	input  wire logic                            limit_neg_n_i,
	input  wire logic                            index_i,
	// Feedback, same clock
	input  wire logic [homing_pkg::DATA_W-1:0]   position_feedback_value_i,
	input  wire logic [ANGLE_W-1:0]              feedback_angle_i,
	// Motion profile
	input  wire logic                            standstill_i,
	input  wire logic                            move_done_i,
	output logic      [homing_pkg::DATA_W-1:0]   vel_cmd_o,
	output logic      [homing_pkg::DATA_W-1:0]   accel_o,
	output logic      [homing_pkg::DATA_W-1:0]   decel_o,
	output logic                                 move_req_o,
	output logic      [homing_pkg::DATA_W-1:0]   move_target_o,
	output logic                                 pos_load_o,
	output logic      [homing_pkg::DATA_W-1:0]   pos_load_value_o,
	// Status
	output logic                                 found_o,
	output logic                                 done_o,
	output logic                                 active_o,
	output logic                                 error_o
);
	import homing_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SEARCH,
		ST_STOP,
		ST_REVERSE,
		ST_INDEX,
		ST_RAMP,
		ST_MOVE,
		ST_ABORT
	} state_t;

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic [1:0]        method;
	logic              dir_pos;
	logic [7:0]        fb_type;
	logic              capture_arm;
	logic [DATA_W-1:0] velocity;
	logic [DATA_W-1:0] home_pos;
	logic [DATA_W-1:0] distance;
	logic [6:0]        factor;

	state_t            state;
	logic              start_cmd;
	logic              go;
	logic              lim_pos_m;
	logic              lim_pos_s;
	logic              lim_neg_m;
	logic              lim_neg_s;
	logic              idx_m;
	logic              idx_s;
	logic              idx_d;
	logic              lim_act;
	logic              idx_event;
	logic              meth_ok;
	logic              fb_ok;
	logic              ev_found;
	logic              ev_done;
	logic              ev_error;
	logic [DATA_W-1:0] search_vel;
	logic [DATA_W-1:0] back_vel;
	logic [DATA_W-1:0] slow_vel;
	logic [DATA_W-1:0] zero_dist;
	logic [38:0]       slow_prod;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two flops before use; idx_d only delays the clean second stage
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			lim_pos_m <= 1'b1;
			lim_pos_s <= 1'b1;
			lim_neg_m <= 1'b1;
			lim_neg_s <= 1'b1;
			idx_m     <= 1'b0;
			idx_s     <= 1'b0;
			idx_d     <= 1'b0;
		end else begin
			lim_pos_m <= limit_pos_n_i;
			lim_pos_s <= lim_pos_m;
			lim_neg_m <= limit_neg_n_i;
			lim_neg_s <= lim_neg_m;
			idx_m     <= index_i;
			idx_s     <= idx_m;
			idx_d     <= idx_s;
		end
	end

	// ---------------------------------------------------------------
	// Derived terms
	// ---------------------------------------------------------------
	// Low pin means active, so a dead switch supply reads as active
	assign lim_act = dir_pos ? ~lim_pos_s : ~lim_neg_s;
	// Index only counts when software armed the capture
	assign idx_event = capture_arm & idx_s & ~idx_d;
	assign go = write_i && (addr_i == OFS_CONTROL)
		&& wdata_i[CTL_START_STOP];
	assign start_cmd = go && (state == ST_IDLE);
	assign fb_ok = (fb_type == FB_INDEX_A) || (fb_type == FB_INDEX_B)
		|| (fb_type == FB_INDEX_C) || (fb_type == FB_INDEX_D);
	assign meth_ok = (method != METH_INDEX) || (fb_ok && capture_arm);
	// Search velocity follows the home direction
	assign search_vel = dir_pos ? velocity : -velocity;
	assign back_vel = -search_vel;
	// Divide by a constant; cheap enough and exact for whole percents
	assign slow_prod = 39'(velocity) * 39'(factor);
	assign slow_vel = dir_pos ? -DATA_W'(slow_prod / 39'(PERCENT_FULL))
		: DATA_W'(slow_prod / 39'(PERCENT_FULL));
	// Distance to angle zero in the direction of travel after reversal
	assign zero_dist = dir_pos
		? -DATA_W'(feedback_angle_i)
		: DATA_W'({1'b0, ~feedback_angle_i} + 1'b1)
		& DATA_W'({1'b0, {ANGLE_W{1'b1}}});

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	// Method, direction, feedback type and capture arming
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			method      <= METH_CURRENT;
			dir_pos     <= 1'b0;
			fb_type     <= 8'h00;
			capture_arm <= 1'b0;
		end else if (write_i) begin
			if (addr_i == OFS_MODE) begin
				method  <= wdata_i[MODE_METH_LSB +: 2];
				dir_pos <= wdata_i[MODE_DIR_BIT];
				fb_type <= wdata_i[MODE_FB_LSB +: 8];
			end
			if (addr_i == OFS_CONTROL)
				capture_arm <= wdata_i[CTL_CAPTURE];
		end
	end

	// Motion settings
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			velocity <= RST_WORD;
			accel_o  <= RST_WORD;
			decel_o  <= RST_WORD;
			home_pos <= RST_WORD;
			distance <= RST_WORD;
			factor   <= RST_FACTOR;
		end else if (write_i) begin
			unique case (addr_i)
				OFS_VELOCITY: velocity <= wdata_i;
				OFS_ACCEL:    accel_o  <= wdata_i;
				OFS_DECEL:    decel_o  <= wdata_i;
				OFS_POSITION: home_pos <= wdata_i;
				OFS_DISTANCE: distance <= wdata_i;
				OFS_FACTOR:   factor   <= wdata_i[6:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register reads
	// ---------------------------------------------------------------
	// Data valid the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= RST_WORD;
		end else if (read_i) begin
			unique case (addr_i)
				OFS_CONTROL:  rdata_o <= {30'h0, capture_arm, active_o};
				OFS_MODE:     rdata_o <= {16'h0, fb_type, 5'h0,
					dir_pos, method};
				OFS_VELOCITY: rdata_o <= velocity;
				OFS_ACCEL:    rdata_o <= accel_o;
				OFS_DECEL:    rdata_o <= decel_o;
				OFS_POSITION: rdata_o <= home_pos;
				OFS_DISTANCE: rdata_o <= distance;
				OFS_FACTOR:   rdata_o <= {25'h0, factor};
				OFS_STATUS:   rdata_o <= {26'h0, ~lim_neg_s, ~lim_pos_s,
					error_o, active_o, done_o, found_o};
				OFS_READOUT:  rdata_o <= position_feedback_value_i;
				default:      rdata_o <= RST_WORD;
			endcase
		end else begin
			rdata_o <= RST_WORD;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// One state per motion phase; load and move requests are pulses
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state            <= ST_IDLE;
			vel_cmd_o        <= RST_WORD;
			move_req_o       <= 1'b0;
			move_target_o    <= RST_WORD;
			pos_load_o       <= 1'b0;
			pos_load_value_o <= RST_WORD;
			ev_found         <= 1'b0;
			ev_done          <= 1'b0;
			ev_error         <= 1'b0;
		end else begin
			move_req_o <= 1'b0;
			pos_load_o <= 1'b0;
			ev_found   <= 1'b0;
			ev_done    <= 1'b0;
			ev_error   <= 1'b0;
			if (go && state != ST_IDLE) begin
				// Stop: ramp down, never report done
				vel_cmd_o <= RST_WORD;
				state     <= ST_ABORT;
			end else begin
				unique case (state)
				ST_IDLE: begin
					vel_cmd_o <= RST_WORD;
					if (start_cmd && !meth_ok) begin
						ev_error <= 1'b1;
					end else if (start_cmd && method == METH_CURRENT) begin
						// Present position becomes home at once
						pos_load_o       <= 1'b1;
						pos_load_value_o <= home_pos;
						ev_found         <= 1'b1;
						state            <= ST_RAMP;
					end else if (start_cmd) begin
						vel_cmd_o <= search_vel;
						state     <= ST_SEARCH;
					end
				end
				ST_SEARCH: begin
					if (lim_act) begin
						vel_cmd_o <= RST_WORD;
						state     <= ST_STOP;
					end
				end
				ST_STOP: begin
					// Switch must stay active until reversal begins
					if (!lim_act) begin
						ev_error <= 1'b1;
						state    <= ST_ABORT;
					end else if (standstill_i) begin
						vel_cmd_o <= back_vel;
						state     <= ST_REVERSE;
					end
				end
				ST_REVERSE: begin
					if (!lim_act) begin
						unique case (method)
						METH_ZERO: begin
							pos_load_o       <= 1'b1;
							pos_load_value_o <= home_pos
								+ zero_dist;
							ev_found         <= 1'b1;
							vel_cmd_o        <= RST_WORD;
							state            <= ST_RAMP;
						end
						METH_INDEX: begin
							vel_cmd_o <= slow_vel;
							state     <= ST_INDEX;
						end
						default: begin
							pos_load_o       <= 1'b1;
							pos_load_value_o <= home_pos;
							ev_found         <= 1'b1;
							vel_cmd_o        <= RST_WORD;
							state            <= ST_RAMP;
						end
						endcase
					end
				end
				ST_INDEX: begin
					if (idx_event) begin
						pos_load_o       <= 1'b1;
						pos_load_value_o <= home_pos;
						ev_found         <= 1'b1;
						vel_cmd_o        <= RST_WORD;
						state            <= ST_RAMP;
					end
				end
				ST_RAMP: begin
					if (standstill_i) begin
						if (method != METH_CURRENT
							|| distance != RST_WORD) begin
							// Return to home plus offset; method 0 gets here only with a nonzero offset
							move_req_o    <= 1'b1;
							move_target_o <= home_pos
								+ distance;
							state         <= ST_MOVE;
						end else begin
							ev_done <= 1'b1;
							state   <= ST_IDLE;
						end
					end
				end
				ST_MOVE: begin
					if (move_done_i) begin
						ev_done <= 1'b1;
						state   <= ST_IDLE;
					end
				end
				ST_ABORT: begin
					vel_cmd_o <= RST_WORD;
					if (standstill_i)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	// A start clears old results; a later set in the same cycle wins
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			found_o <= 1'b0;
			done_o  <= 1'b0;
			error_o <= 1'b0;
		end else begin
			if (start_cmd) begin
				found_o <= 1'b0;
				done_o  <= 1'b0;
				error_o <= 1'b0;
			end
			if (ev_found)
				found_o <= 1'b1;
			if (ev_done)
				done_o <= 1'b1;
			if (ev_error)
				error_o <= 1'b1;
		end
	end

	// Active follows the sequencer, one cycle behind the state change
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			active_o <= 1'b0;
		else
			active_o <= (state != ST_IDLE)
				&& (state != ST_ABORT);
	end
endmodule // axis_homing_sequencer

`default_nettype wire

// ===== bench/homing_props.sv
// Port-level checks on the axis homing sequencer, bound to its top.
// Assumes home settings change only while the axis stands idle.
`timescale 1ns/1ps
`default_nettype none
module homing_props (
	// Clock, reset and register port
	input wire logic        clock_i,
	input wire logic        reset_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        write_i,
	input wire logic        read_i,
	input wire logic [31:0] rdata_o,
	// Profile side and status
	input wire logic        standstill_i,
	input wire logic [31:0] vel_cmd_o,
	input wire logic        move_req_o,
	input wire logic [31:0] move_target_o,
	input wire logic        pos_load_o,
	input wire logic [31:0] pos_load_value_o,
	input wire logic        found_o,
	input wire logic        done_o,
	input wire logic        active_o,
	input wire logic        error_o
);
	import homing_pkg::*;
	// ----------------------------------------------------------------
	// Shadow of the home settings
	// ----------------------------------------------------------------
	logic [31:0] home_pos;
	logic [31:0] home_dist;
	logic [1:0]  meth;
	wire         ctl_wr;
	wire         idle_wr;
	assign ctl_wr = write_i && addr_i == OFS_CONTROL && wdata_i[0];
	// A standing, inactive axis takes the command as a start
	assign idle_wr = ctl_wr && !active_o && standstill_i;

	// Track register writes so targets can be predicted
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			home_pos <= 32'h0;
			home_dist <= 32'h0;
			meth <= 2'h0;
		end else if (write_i) begin
			if (addr_i == OFS_POSITION) home_pos <= wdata_i;
			if (addr_i == OFS_DISTANCE) home_dist <= wdata_i;
			if (addr_i == OFS_MODE) meth <= wdata_i[1:0];
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	a_load_sets_found: assert property (pos_load_o |=> found_o)
		else $error("found flag missing after position load");
	a_found_holds: assert property (found_o && !ctl_wr |=> found_o)
		else $error("found flag dropped without a start");
	a_done_holds: assert property (done_o && !ctl_wr |=> done_o)
		else $error("done flag dropped without a start");
	a_done_ends_active: assert property ($rose(done_o) |=> !active_o)
		else $error("active flag still high after done");
	a_error_holds: assert property (error_o && !ctl_wr |=> error_o)
		else $error("error flag dropped without a start");
	a_start_runs: assert property (idle_wr
		|-> ##[1:3] (active_o || error_o))
		else $error("start neither activated nor refused");
	a_load_value: assert property (pos_load_o && meth != METH_ZERO
		|-> pos_load_value_o == home_pos) else $error("wrong home load value");
	a_move_target: assert property (move_req_o
		|-> move_target_o == home_pos + home_dist) else $error("wrong target");
	a_stop_ramps: assert property (ctl_wr && active_o
		|=> vel_cmd_o == 32'h0 ##1 !active_o) else $error("stop not obeyed");
	a_start_clears: assert property (idle_wr
		|=> !found_o && !done_o && !error_o)
		else $error("flags not cleared by start");
	a_read_clean: assert property (!read_i |=> rdata_o == 32'h0)
		else $error("read data outside the read cycle");

	c_load: cover property (pos_load_o);
	c_done: cover property ($rose(done_o));
	c_error: cover property ($rose(error_o));
endmodule // homing_props

bind axis_homing_sequencer homing_props u_homing_props (.*);
`default_nettype wire

// ===== bench/axis_partner.sv
// Far side of the sequencer: limit switches, index and a stepping profile.
// Assumes the sequencer drives its profile outputs from registers.
`timescale 1ns/1ps
`default_nettype none
module axis_partner (
	// Clock, reset and bench controls
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        rewind_i,
	input  wire logic [3:0]  coast_i,
	// Commands from the sequencer
	input  wire logic [31:0] vel_i,
	input  wire logic        move_req_i,
	input  wire logic [31:0] target_i,
	input  wire logic        load_i,
	input  wire logic [31:0] load_value_i,
	// Pins and profile status
	output logic      [31:0] pos_o,
	output logic             limit_pos_n_o,
	output logic             limit_neg_n_o,
	output logic             index_o,
	output logic             standstill_o,
	output logic             move_done_o
);
	logic [2:0] div;
	logic [3:0] left;
	logic       back;
	logic [2:0] mv;
	wire        step;
	assign step = div == 3'h0;

	// One step per eight cycles; coast steps model a slow ramp down
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pos_o <= 32'h0;
			left <= 4'h0;
			back <= 1'b0;
		end else if (rewind_i) begin
			pos_o <= 32'h0;
		end else if (load_i) begin
			pos_o <= load_value_i;
		end else if (mv == 3'h1) begin
			pos_o <= target_i;
		end else if (vel_i != 32'h0) begin
			back <= vel_i[31];
			left <= coast_i;
			if (step) pos_o <= vel_i[31] ? pos_o - 32'h1 : pos_o + 32'h1;
		end else if (left != 4'h0 && step) begin
			left <= left - 4'h1;
			pos_o <= back ? pos_o - 32'h1 : pos_o + 32'h1;
		end
	end

	// Absolute moves finish six cycles after the request
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			div <= 3'h0;
			mv <= 3'h0;
			move_done_o <= 1'b0;
		end else begin
			div <= div + 3'h1;
			move_done_o <= mv == 3'h1;
			if (move_req_i) mv <= 3'h5;
			else if (mv != 3'h0) mv <= mv - 3'h1;
		end
	end

	// Switches read active low, so a dead switch supply looks tripped
	assign limit_pos_n_o = !($signed(pos_o) >= 6
		&& $signed(pos_o) < 10);
	assign limit_neg_n_o = !($signed(pos_o) <= -6
		&& $signed(pos_o) > -10);
	assign index_o = vel_i != 32'h0 && pos_o[1:0] == 2'h0 && div[2];
	assign standstill_o = vel_i == 32'h0 && left == 4'h0 && mv == 3'h0;
endmodule // axis_partner
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench: register tasks drive every homing method.
// Assumes the far side is the stepping model in axis_partner.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import homing_pkg::*;
	localparam logic [31:0] VEL  = 32'h40;
	localparam logic [31:0] HPOS = 32'h100;
	localparam logic [31:0] DIST = 32'h5;
	localparam logic [31:0] SLOW = VEL * 32'h19 / 32'h64;
	logic        clock_i, reset_i, write_i, read_i, rewind;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i, rdata_o, vel_cmd_o, accel_o, decel_o;
	logic [31:0] move_target_o, pos_load_value_o, position_feedback_value_i;
	logic        limit_pos_n_i, limit_neg_n_i, index_i, standstill_i;
	logic        move_done_i, move_req_o, pos_load_o;
	logic        found_o, done_o, active_o, error_o;
	logic [3:0]  coast;
	logic [15:0] feedback_angle_i;
	logic [31:0] n_moves, load_val, first_vel, last_vel;
	logic [7:0]  fb_tab [6] = '{8'h00, FB_INDEX_A, FB_INDEX_B,
		FB_INDEX_B, FB_INDEX_C, FB_INDEX_D};
	int          n_errors, n_checks;

	axis_homing_sequencer u_axis_homing_sequencer (.*);
	axis_partner u_axis_partner (.clock_i(clock_i), .reset_i(reset_i),
		.rewind_i(rewind), .coast_i(coast), .vel_i(vel_cmd_o),
		.move_req_i(move_req_o), .target_i(move_target_o),
		.load_i(pos_load_o), .load_value_i(pos_load_value_o),
		.pos_o(position_feedback_value_i), .limit_pos_n_o(limit_pos_n_i),
		.limit_neg_n_o(limit_neg_n_i), .index_o(index_i),
		.standstill_o(standstill_i), .move_done_o(move_done_i));

	always #2 clock_i = ~clock_i;

	// Record loads, moves and the speeds the sequencer commands
	always @(posedge clock_i) begin
		if (pos_load_o) load_val = pos_load_value_o;
		if (move_req_o) n_moves = n_moves + 32'h1;
		if (vel_cmd_o != 32'h0 && first_vel == 32'h0) first_vel = vel_cmd_o;
		if (vel_cmd_o != 32'h0) last_vel = vel_cmd_o;
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		write_i <= 1'b1;
		@(posedge clock_i);
		write_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
		@(posedge clock_i);
		addr_i <= a;
		read_i <= 1'b1;
		@(posedge clock_i);
		read_i <= 1'b0;
		#1;
		check(nm, e, rdata_o);
	endtask
	// Start a method and wait, bounded, for it to finish
	task automatic home(input logic [31:0] mode, ctl);
		n_moves = 32'h0;
		load_val = 32'h0;
		first_vel = 32'h0;
		last_vel = 32'h0;
		wr(OFS_MODE, mode);
		// Capture is armed by its own write, before the start pulse
		wr(OFS_CONTROL, ctl & 32'h2);
		wr(OFS_CONTROL, ctl);
		check("flags at start", 32'h0, {found_o, done_o, error_o});
		repeat (3) @(posedge clock_i);
		repeat (4000) if (active_o) @(posedge clock_i);
		check("homing time", 32'h0, {31'h0, active_o});
		repeat (8) @(posedge clock_i);
		#1;
	endtask
	task automatic verify(input logic [31:0] ld, mv, st, fb);
		check("home load value", ld, load_val);
		check("final moves", mv, n_moves);
		rd(OFS_STATUS, st, "status");
		rd(OFS_READOUT, fb, "readout");
	endtask
	// Let the axis stop, then put it back at zero for the next test
	task automatic settle(input string nm);
		repeat (400) if (!standstill_i) @(posedge clock_i);
		check("standstill", 32'h1, {31'h0, standstill_i});
		@(posedge clock_i);
		rewind <= 1'b1;
		coast <= 4'h1;
		@(posedge clock_i);
		rewind <= 1'b0;
		#1;
		$display("test %s done", nm);
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{clock_i, reset_i, write_i, read_i, rewind} = 5'b01000;
		{addr_i, wdata_i, n_errors, n_checks} = '0;
		coast = 4'h1;
		feedback_angle_i = 16'h0123;
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		rd(OFS_FACTOR, {25'h0, RST_FACTOR}, "factor reset");
		rd(OFS_STATUS, 32'h0, "status reset");
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0, "unmapped read");
		wr(OFS_VELOCITY, VEL);
		wr(OFS_ACCEL, 32'h11);
		wr(OFS_DECEL, 32'h22);
		wr(OFS_POSITION, HPOS);
		wr(OFS_FACTOR, 32'h19);
		check("accel setting", 32'h11, accel_o);
		check("decel setting", 32'h22, decel_o);
		settle("registers");
		for (int i = 0; i < 2; i++) begin
			wr(OFS_DISTANCE, i ? DIST : 32'h0);
			home(32'h0, 32'h1);
			check("search speed", 32'h0, first_vel);
			verify(HPOS, 32'(i), 32'h3, HPOS + (i ? DIST : 32'h0));
			settle("current position");
		end
		home(32'h5, 32'h1);
		check("approach speed", VEL, first_vel);
		check("reverse speed", -VEL, last_vel);
		verify(HPOS, 32'h1, 32'h3, HPOS + DIST);
		settle("limit");
		home(32'h6, 32'h1);
		verify(HPOS - 32'h123, 32'h1, 32'h3, HPOS + DIST);
		settle("zero angle");
		// Negative start: reversal runs upward, so zero lies ahead
		home(32'h2, 32'h1);
		verify(HPOS + 32'hfedd, 32'h1, 32'h3, HPOS + DIST);
		settle("zero angle negative");
		for (int i = 0; i < 6; i++) begin
			home({16'h0, fb_tab[i], 8'h03}, i == 2 ? 32'h1 : 32'h3);
			if (i == 0 || i == 2) begin
				verify(32'h0, 32'h0, 32'h8, 32'h0);
			end else begin
				check("approach speed", -VEL, first_vel);
				check("index search speed", SLOW, last_vel);
				verify(HPOS, 32'h1, 32'h3, HPOS + DIST);
			end
			settle("index");
		end
		coast = 4'h8;
		home(32'h5, 32'h1);
		rd(OFS_STATUS, 32'h8, "status after overshoot");
		check("moves after overshoot", 32'h0, n_moves);
		settle("overshoot");
		wr(OFS_CONTROL, 32'h1);
		repeat (20) @(posedge clock_i);
		wr(OFS_CONTROL, 32'h1);
		check("speed after stop", 32'h0, vel_cmd_o);
		rd(OFS_STATUS, 32'h0, "status after stop");
		settle("stop");
		test_done;
	end

	// Watchdog well beyond the longest expected run
	initial begin
		repeat (50000) @(posedge clock_i);
		n_errors++;
		$display("unexpected run length: expected %h, seen %h", 1'b0, 1'b1);
		test_done;
	end
endmodule // testbench
`default_nettype wire
